// ---- pkg/irq_status_pkg.sv ----
// Package: register map, field positions, reset values and timing for
// the host controller interrupt status block.
// Assumes a 100 MHz APB clock and 32-bit APB data.
package irq_status_pkg;

  // Register byte offsets
  localparam logic [11:0] STATUS_OFFSET  = 12'h310;
  localparam logic [11:0] ENABLE_OFFSET  = 12'h314;
  localparam logic [11:0] POWER_OFFSET   = 12'h318;
  localparam logic [11:0] WAKE_OFFSET    = 12'h31C;

  // Status and enable field positions
  localparam int ISO_BIT      = 9;
  localparam int ASYNC_BIT    = 8;
  localparam int PERIODIC_BIT = 7;
  localparam int CLOCK_BIT    = 6;
  localparam int SUSPEND_BIT  = 5;
  localparam int DMA_BIT      = 3;
  localparam int FRAME_BIT    = 1;
  localparam int RSVD_HI_BIT  = 2;
  localparam int RSVD_LO_BIT  = 0;

  localparam logic [31:0] EVENT_MASK   = 32'h0000_03EA;
  localparam logic [31:0] RSVD_ONE_MASK = 32'h0000_0005;

  // Reset values
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
  localparam logic [15:0] WAKE_RESET   = 16'h03E8;
  localparam logic        GATE_RESET   = 1'b0;

  // Reserved bits 2 and 0 rise after this settling time
  localparam int SETTLE_NS     = 1000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Wake tick: the wake field counts in microseconds
  localparam int WAKE_UNIT_NS     = 1000;
  localparam int WAKE_UNIT_CYCLES = WAKE_UNIT_NS / CLK_PERIOD_NS;

  // Hardware event strobes, one cycle each
  typedef struct packed {
    logic iso_done;
    logic async_done;
    logic periodic_done;
    logic clock_stable;
    logic suspend_entered;
    logic dma_finished;
    logic frame_start;
  } event_t;

  // APB request as seen by the slave
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef enum logic [2:0] {
    WAKE_IDLE  = 3'b001,
    WAKE_AWAKE = 3'b010,
    WAKE_DONE  = 3'b100
  } wake_state_t;

endpackage

// ---- src/irq_settle_timer.sv ----
// Settling timer: raises done once a fixed cycle count has passed
// after reset release. Assumes pclk domain, async active-low reset.
`timescale 1ns/100ps
`default_nettype none
module irq_settle_timer
(
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      done_q
);

  localparam int CW = 16;
  logic [CW-1:0] count_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_q <= '0;
      done_q  <= 1'b0;
    end
    else if (!done_q)
    begin
      count_q <= count_q + 16'h0001;
      done_q  <= (count_q == CW'(irq_status_pkg::SETTLE_CYCLES - 1));
    end
  end

endmodule
`default_nettype wire

// ---- src/irq_wake_timer.sv ----
// Wake timer: after a service access during suspend, holds awake
// for the programmed number of microsecond ticks.
// Assumes pclk domain, async active-low reset.
`timescale 1ns/100ps
`default_nettype none
module irq_wake_timer
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        suspended,
  input  wire logic        access,
  input  wire logic [15:0] wake_time,
  output logic             awake_q
);

  irq_status_pkg::wake_state_t state_q;
  logic [15:0] ticks_q;
  logic [15:0] sub_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= irq_status_pkg::WAKE_IDLE;
      ticks_q <= '0;
      sub_q   <= '0;
      awake_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        irq_status_pkg::WAKE_IDLE:
        begin
          if (suspended && access && wake_time != 16'h0000)
          begin
            state_q <= irq_status_pkg::WAKE_AWAKE;
            ticks_q <= wake_time;
            sub_q   <= '0;
            awake_q <= 1'b1;
          end
        end
        irq_status_pkg::WAKE_AWAKE:
        begin
          if (access)
          begin
            ticks_q <= wake_time;
            sub_q   <= '0;
          end
          else if (sub_q == 16'(irq_status_pkg::WAKE_UNIT_CYCLES - 1))
          begin
            sub_q <= '0;
            if (ticks_q == 16'h0001)
            begin
              state_q <= irq_status_pkg::WAKE_DONE;
              awake_q <= 1'b0;
            end
            ticks_q <= ticks_q - 16'h0001;
          end
          else
          begin
            sub_q <= sub_q + 16'h0001;
          end
        end
        irq_status_pkg::WAKE_DONE:
        begin
          state_q <= irq_status_pkg::WAKE_IDLE;
        end
        default:
        begin
          state_q <= irq_status_pkg::WAKE_IDLE;
          awake_q <= 1'b0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ---- src/irq_event_status.sv ----
// Interrupt status block: sticky event flags, enable mask, global gate,
// wake window and APB slave. Event strobes come from pclk logic.
// Notes on behaviour
// - Isochronous descriptor completion sets bit 9.
// - Asynchronous list descriptor completion sets bit 8.
// - Periodic interrupt descriptor completion sets bit 7.
// - Internal clocks stable sets bit 6.
// - Entry into suspend sets bit 5.
// - Access while suspended keeps device awake for programmed wake time.
// - DMA transfer completion sets bit 3.
// - Each start of frame sets bit 1.
// - Interrupt line asserted only for flags whose enable bit is set.
// - Reserved bits 2 and 0 read zero after reset, one shortly after.
// - Writing one clears a flag; writing zero leaves it.
// - Flags record regardless of global gate; gate affects only the line.
//
// Local design decision: the APB register port.
`timescale 1ns/100ps
`default_nettype none
module irq_event_status
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire irq_status_pkg::event_t events,
  input  wire logic                   suspended,
  output logic                        irq,
  output logic                        awake
);

  ////////////////////////////////////////////////////////////////////////
  // Decode

  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
    hit = (addr == off);
  endfunction

  irq_status_pkg::apb_req_t req;
  assign req = '{psel: psel, penable: penable, pwrite: pwrite,
                 paddr: paddr, pwdata: pwdata};

  logic access_phase;
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic [31:0] wmask;
  assign access_phase = req.psel && req.penable && pready;
  assign wr_en = access_phase && req.pwrite;
  assign rd_en = access_phase && !req.pwrite;
  assign wmask = req.pwdata & lane_mask(pstrb);
  assign mapped = hit(req.paddr, irq_status_pkg::STATUS_OFFSET)
               || hit(req.paddr, irq_status_pkg::ENABLE_OFFSET)
               || hit(req.paddr, irq_status_pkg::POWER_OFFSET)
               || hit(req.paddr, irq_status_pkg::WAKE_OFFSET);

  ////////////////////////////////////////////////////////////////////////
  // Event flags

  function automatic logic sticky_next(input logic cur, input logic ev, input logic clr);
    sticky_next = ev || (cur && !clr);
  endfunction

  logic [31:0] clr_vec;
  logic [31:0] status_word;
  logic [31:0] status_d;
  logic [31:0] status_view;
  logic        settled;
  logic        iso_q;
  logic        iso_d;
  logic        async_q;
  logic        async_d;
  logic        periodic_q;
  logic        periodic_d;
  logic        clock_q;
  logic        clock_d;
  logic        suspend_q;
  logic        suspend_d;
  logic        dma_q;
  logic        dma_d;
  logic        frame_q;
  logic        frame_d;

  assign clr_vec = (wr_en && hit(req.paddr, irq_status_pkg::STATUS_OFFSET))
                   ? (wmask & irq_status_pkg::EVENT_MASK) : 32'h0000_0000;

  assign iso_d = sticky_next(iso_q, events.iso_done,
                             clr_vec[irq_status_pkg::ISO_BIT]);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      iso_q <= irq_status_pkg::STATUS_RESET[irq_status_pkg::ISO_BIT];
    else
      iso_q <= iso_d;
  end

  assign async_d = sticky_next(async_q, events.async_done,
                               clr_vec[irq_status_pkg::ASYNC_BIT]);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      async_q <= irq_status_pkg::STATUS_RESET[irq_status_pkg::ASYNC_BIT];
    else
      async_q <= async_d;
  end

  assign periodic_d = sticky_next(periodic_q, events.periodic_done,
                                  clr_vec[irq_status_pkg::PERIODIC_BIT]);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      periodic_q <= irq_status_pkg::STATUS_RESET[irq_status_pkg::PERIODIC_BIT];
    else
      periodic_q <= periodic_d;
  end

  assign clock_d = sticky_next(clock_q, events.clock_stable,
                               clr_vec[irq_status_pkg::CLOCK_BIT]);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      clock_q <= irq_status_pkg::STATUS_RESET[irq_status_pkg::CLOCK_BIT];
    else
      clock_q <= clock_d;
  end

  assign suspend_d = sticky_next(suspend_q, events.suspend_entered,
                                 clr_vec[irq_status_pkg::SUSPEND_BIT]);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      suspend_q <= irq_status_pkg::STATUS_RESET[irq_status_pkg::SUSPEND_BIT];
    else
      suspend_q <= suspend_d;
  end

  assign dma_d = sticky_next(dma_q, events.dma_finished,
                             clr_vec[irq_status_pkg::DMA_BIT]);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dma_q <= irq_status_pkg::STATUS_RESET[irq_status_pkg::DMA_BIT];
    else
      dma_q <= dma_d;
  end

  assign frame_d = sticky_next(frame_q, events.frame_start,
                               clr_vec[irq_status_pkg::FRAME_BIT]);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      frame_q <= irq_status_pkg::STATUS_RESET[irq_status_pkg::FRAME_BIT];
    else
      frame_q <= frame_d;
  end

  // Flags as one register word
  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[irq_status_pkg::ISO_BIT]      = iso_q;
    status_word[irq_status_pkg::ASYNC_BIT]    = async_q;
    status_word[irq_status_pkg::PERIODIC_BIT] = periodic_q;
    status_word[irq_status_pkg::CLOCK_BIT]    = clock_q;
    status_word[irq_status_pkg::SUSPEND_BIT]  = suspend_q;
    status_word[irq_status_pkg::DMA_BIT]      = dma_q;
    status_word[irq_status_pkg::FRAME_BIT]    = frame_q;
  end

  always_comb
  begin
    status_d = 32'h0000_0000;
    status_d[irq_status_pkg::ISO_BIT]      = iso_d;
    status_d[irq_status_pkg::ASYNC_BIT]    = async_d;
    status_d[irq_status_pkg::PERIODIC_BIT] = periodic_d;
    status_d[irq_status_pkg::CLOCK_BIT]    = clock_d;
    status_d[irq_status_pkg::SUSPEND_BIT]  = suspend_d;
    status_d[irq_status_pkg::DMA_BIT]      = dma_d;
    status_d[irq_status_pkg::FRAME_BIT]    = frame_d;
  end

  // reserved bits read one once settled
  assign status_view = status_word | (settled ? irq_status_pkg::RSVD_ONE_MASK : 32'h0000_0000);

  irq_settle_timer u_settle
  (
    .pclk    (pclk),
    .presetn (presetn),
    .done_q  (settled)
  );

  ////////////////////////////////////////////////////////////////////////
  // Enable, gate and wake time

  logic [31:0] enable_q;
  logic [31:0] enable_d;
  logic        gate_q;
  logic [15:0] wake_time_q;
  logic [15:0] wake_time_d;

  always_comb
  begin
    enable_d = enable_q;
    if (wr_en && hit(req.paddr, irq_status_pkg::ENABLE_OFFSET))
      enable_d = ((enable_q & ~lane_mask(pstrb)) | wmask) & irq_status_pkg::EVENT_MASK;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      enable_q <= irq_status_pkg::ENABLE_RESET;
    else
      enable_q <= enable_d;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      gate_q <= irq_status_pkg::GATE_RESET;
    else if (wr_en && hit(req.paddr, irq_status_pkg::POWER_OFFSET) && pstrb[0])
      gate_q <= req.pwdata[0];
  end

  always_comb
  begin
    wake_time_d = wake_time_q;
    if (wr_en && hit(req.paddr, irq_status_pkg::WAKE_OFFSET))
    begin
      if (pstrb[2])
        wake_time_d[7:0] = req.pwdata[23:16];
      if (pstrb[3])
        wake_time_d[15:8] = req.pwdata[31:24];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wake_time_q <= irq_status_pkg::WAKE_RESET;
    else
      wake_time_q <= wake_time_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // Wake window

  logic awake_w;

  irq_wake_timer u_wake
  (
    .pclk      (pclk),
    .presetn   (presetn),
    .suspended (suspended),
    .access    (access_phase),
    .wake_time (wake_time_q),
    .awake_q   (awake_w)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      awake <= 1'b0;
    else
      awake <= awake_w;
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt line

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= gate_q && |(status_d & enable_q);
  end

  ////////////////////////////////////////////////////////////////////////
  // APB slave

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= req.psel && !req.penable;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr <= 1'b0;
    else
      pslverr <= req.psel && !req.penable && !mapped;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (req.psel && !req.penable && !req.pwrite)
    begin
      if (hit(req.paddr, irq_status_pkg::STATUS_OFFSET))
        prdata <= status_view;
      else if (hit(req.paddr, irq_status_pkg::ENABLE_OFFSET))
        prdata <= enable_q;
      else if (hit(req.paddr, irq_status_pkg::POWER_OFFSET))
        prdata <= {31'h0000_0000, gate_q};
      else if (hit(req.paddr, irq_status_pkg::WAKE_OFFSET))
        prdata <= {wake_time_q, 16'h0000};
      else
        prdata <= 32'h0000_0000;
    end
    else if (rd_en)
      prdata <= prdata;
  end

endmodule
`default_nettype wire

// ---- sim/irq_event_status_properties.sv ----
// Checker: port-level properties of the interrupt status block.
// Assumes one pclk domain with async active-low presetn.
`timescale 1ns/100ps
`default_nettype none
module irq_event_status_properties
(
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [11:0]            paddr,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire irq_status_pkg::event_t events,
  input wire logic                   suspended,
  input wire logic                   irq,
  input wire logic                   awake
);
  logic [6:0] up_q;
  logic       rd_st;
  assign rd_st = pready && !pwrite && paddr == irq_status_pkg::STATUS_OFFSET;
  // Cycles since reset release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      up_q <= 7'h00;
    else if (up_q != 7'h7F)
      up_q <= up_q + 7'h01;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  a_ready_after_setup: assert property (
    psel && !penable |=> pready && penable) else $error("no ready after setup");
  a_ready_one_cycle: assert property (
    pready |=> !pready) else $error("ready held too long");
  a_unmapped_err: assert property (
    psel && !penable && (paddr < irq_status_pkg::STATUS_OFFSET
    || paddr > irq_status_pkg::WAKE_OFFSET) |=> pslverr) else $error("no error");
  a_rsvd_reads_zero: assert property (
    rd_st |-> prdata[31:10] == 22'h0 && !prdata[4]) else $error("reserved bits set");
  a_rsvd_early_zero: assert property (
    rd_st && up_q < 7'h5A |-> !prdata[2] && !prdata[0]) else $error("early one");
  a_rsvd_late_one: assert property (
    rd_st && up_q > 7'h6E |-> prdata[2] && prdata[0]) else $error("late zero");
  a_irq_has_cause: assert property (
    $rose(irq) |-> $past(|events) || $past(psel && penable && pwrite)
    || $past(psel && penable && pwrite, 2)) else $error("irq without cause");
  a_awake_needs_susp: assert property (
    $rose(awake) |-> $past(suspended) || $past(suspended, 2)
    || $past(suspended, 3)) else $error("awake outside suspend");
endmodule

bind irq_event_status irq_event_status_properties chk_u
(
  .pclk     (pclk),
  .presetn  (presetn),
  .psel     (psel),
  .penable  (penable),
  .pwrite   (pwrite),
  .paddr    (paddr),
  .prdata   (prdata),
  .pready   (pready),
  .pslverr  (pslverr),
  .events   (events),
  .suspended(suspended),
  .irq      (irq),
  .awake    (awake)
);
`default_nettype wire

// ---- sim/apb_host_model.sv ----
// Host model: APB master through which software reaches the block.
// Assumes xfer is called just after a rising pclk edge.
`timescale 1ns/100ps
`default_nettype none
module apb_host_model
(
  input  wire logic        pclk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb
);
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    pstrb   = 4'h0;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= (a == irq_status_pkg::STATUS_OFFSET) ? d & irq_status_pkg::EVENT_MASK : d;
    pstrb   <= 4'hF;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// ---- sim/usb_host_irq_status_tb.sv ----
// Testbench: event strobes and APB traffic; checks flags, irq and wake.
// Assumes package, design, host model and checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module usb_host_irq_status_tb;
  typedef struct packed {
    logic [6:0] ev;
    logic [9:0] en;
    logic       gate;
    logic [9:0] st;
    logic       irq_e;
  } row_t;
  localparam logic [31:0] ONES = irq_status_pkg::RSVD_ONE_MASK;
  localparam logic [11:0] ST   = irq_status_pkg::STATUS_OFFSET;
  logic                   pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic                   suspended, irq, awake, err;
  logic [11:0]            paddr;
  logic [3:0]             pstrb;
  logic [31:0]            prdata, pwdata, rd;
  irq_status_pkg::event_t events;
  row_t                   rows [9];
  int                     errors = 0;
  int                     total_checks = 0;
  always #5 pclk = ~pclk;
  irq_event_status dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .events(events), .suspended(suspended),
    .irq(irq), .awake(awake));
  apb_host_model host_u (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb));
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rw(input logic w, input logic [11:0] a, input logic [31:0] d);
    host_u.xfer(w, a, d, rd, err);
  endtask
  task automatic pulse(input logic [6:0] v);
    events <= irq_status_pkg::event_t'(v);
    @(posedge pclk);
    events <= '0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////
  initial
  begin
    pclk      = 1'b0;
    presetn   = 1'b0;
    events    = '0;
    suspended = 1'b0;
    rows[0] = {7'h40, 10'h200, 1'b1, 10'h200, 1'b1};
    rows[1] = {7'h20, 10'h100, 1'b1, 10'h100, 1'b1};
    rows[2] = {7'h10, 10'h080, 1'b1, 10'h080, 1'b1};
    rows[3] = {7'h08, 10'h040, 1'b1, 10'h040, 1'b1};
    rows[4] = {7'h04, 10'h020, 1'b1, 10'h020, 1'b1};
    rows[5] = {7'h02, 10'h008, 1'b1, 10'h008, 1'b1};
    rows[6] = {7'h01, 10'h002, 1'b1, 10'h002, 1'b1};
    rows[7] = {7'h40, 10'h100, 1'b1, 10'h200, 1'b0};
    rows[8] = {7'h01, 10'h002, 1'b0, 10'h002, 1'b0};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rw(1'b0, ST, 32'h0);
    chk(rd, 32'h0);
    rw(1'b0, irq_status_pkg::ENABLE_OFFSET, 32'h0);
    chk(rd, irq_status_pkg::ENABLE_RESET);
    $display("test reset done");
    repeat (110) @(posedge pclk);
    foreach (rows[i])
    begin
      rw(1'b1, irq_status_pkg::ENABLE_OFFSET, {22'h0, rows[i].en});
      rw(1'b1, irq_status_pkg::POWER_OFFSET, {31'h0, rows[i].gate});
      pulse(rows[i].ev);
      chk({31'h0, irq}, {31'h0, rows[i].irq_e});
      rw(1'b0, ST, 32'h0);
      chk(rd, {22'h0, rows[i].st} | ONES);
      rw(1'b1, ST, {22'h0, rows[i].st});
      @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      rw(1'b0, ST, 32'h0);
      chk(rd, ONES);
    end
    $display("test table done");
    pulse(7'h02);
    rw(1'b1, ST, 32'h0);
    rw(1'b0, ST, 32'h0);
    chk(rd, 32'h0000_0008 | ONES);
    fork
      rw(1'b1, ST, 32'h0000_0008);
      begin
        @(posedge pclk);
        events <= irq_status_pkg::event_t'(7'h02);
        @(posedge pclk);
        events <= '0;
      end
    join
    rw(1'b0, ST, 32'h0);
    chk(rd, 32'h0000_0008 | ONES);
    rw(1'b1, ST, 32'h0000_0008);
    $display("test clear done");
    rw(1'b0, 12'h320, 32'h0);
    chk({err, rd[30:0]}, 32'h8000_0000);
    $display("test unmapped done");
    rw(1'b1, irq_status_pkg::WAKE_OFFSET, 32'h0001_0000);
    suspended <= 1'b1;
    @(posedge pclk);
    rw(1'b0, ST, 32'h0);
    repeat (2) @(posedge pclk);
    chk({31'h0, awake}, 32'h1);
    repeat (110) @(posedge pclk);
    chk({31'h0, awake}, 32'h0);
    $display("test wake done");
    pulse(7'h40);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({30'h0, irq, awake}, 32'h0);
    rw(1'b0, ST, 32'h0);
    chk(rd, irq_status_pkg::STATUS_RESET);
    $display("test reset again done");
    end_of_test;
  end
  initial
  begin
    repeat (5000) @(posedge pclk);
    errors++;
    $display("FAIL %0t watchdog expired", $time);
    end_of_test;
  end
endmodule
`default_nettype wire
